// >>> src/usdfta_top.sv
/*
  Data-access side of a UART: a sixteen-word shadow window onto the receive
  buffer / transmit holding path, receive and transmit FIFOs, and the FIFO test
  access mode, all behind an APB slave. Also holds the FIFO module.
  Assumes framers on the same clock deliver received bytes as one-cycle strobes
  and take transmit bytes with a valid/ready handshake; FIFO enable and
  infrared mode come from line-control logic on the same clock.
*/
// Our own choice: the APB register port.
`timescale 1ns/1ps

module usdfta_fifo
  import usdfta_pkg::*;
#(
  parameter int unsigned WIDTH = CHAR_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clear,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [PW:0]      cnt_q, cnt_d;
  logic             push, pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      return '0;
    end
    return p + PW'(1);
  endfunction : ptr_inc

  assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (clear) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end else begin
      if (push) begin
        mem_d[wr_q] = in_data;
        wr_d        = ptr_inc(wr_q);
      end
      if (pop) begin
        rd_d = ptr_inc(rd_q);
      end
      if (push && !pop) begin
        cnt_d = cnt_q + (PW+1)'(1);
      end else if (pop && !push) begin
        cnt_d = cnt_q - (PW+1)'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    mem_q <= mem_d;
    if (sys_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

endmodule : usdfta_fifo

module usdfta_top
#(
  parameter bit          FIFO_ACCESS = 1'b1,
  parameter int unsigned DEPTH       = usdfta_pkg::FIFO_DEPTH
) (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [usdfta_pkg::ADDR_W-1:0] paddr,
  input  wire logic [usdfta_pkg::DATA_W-1:0] pwdata,
  output logic      [usdfta_pkg::DATA_W-1:0] prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          fifo_en,
  input  wire logic                          ir_mode,
  input  wire logic                          rx_ser_valid,
  input  wire logic [usdfta_pkg::CHAR_W-1:0] rx_ser_data,
  input  wire logic                          rx_ir_valid,
  input  wire logic [usdfta_pkg::CHAR_W-1:0] rx_ir_data,
  output logic                               tx_ser_valid,
  output logic                               tx_ir_valid,
  output logic      [usdfta_pkg::CHAR_W-1:0] tx_char_data,
  input  wire logic                          tx_char_ready,
  output logic                               rx_data_ready,
  output logic                               tx_holding_empty,
  output logic                               overrun_err
);
  import usdfta_pkg::*;

  // apb slave state
  logic [DATA_W-1:0] prdata_q, prdata_d;
  logic              pready_q, pready_d;
  logic              pslverr_q, pslverr_d;
  // data path state
  logic              test_q, test_d;
  logic [CHAR_W-1:0] rx_buf_q, rx_buf_d;
  logic              rx_full_q, rx_full_d;
  logic [CHAR_W-1:0] tx_hold_q, tx_hold_d;
  logic              tx_full_q, tx_full_d;
  logic              ovr_q, ovr_d;
  logic              txs_v_q, txs_v_d, txi_v_q, txi_v_d;
  logic [CHAR_W-1:0] tx_out_q, tx_out_d;
  logic              rdy_q, rdy_d, tx_holding_empty_q, tx_holding_empty_d;

  logic              setup;
  logic              access;
  logic              wr_slot;
  logic              rd_slot;
  logic              wr_test;
  logic              rd_stat;
  logic              rx_in_v;
  logic              rx_in_rdy;
  logic              rx_out_v;
  logic              rx_out_rdy;
  logic              tx_in_v;
  logic              tx_in_rdy;
  logic              tx_out_v;
  logic              tx_out_rdy;
  logic              ovr_set;
  logic [CHAR_W-1:0] rx_in_d, rx_head, tx_head;
  logic              line_v, line_slot_free, clear_fifos;
  logic [CHAR_W-1:0] line_d;

  function automatic logic slot_hit(input logic [ADDR_W-1:0] a);
    return (a >= SHADOW_SLOT0) && (a <= SHADOW_SLOT15) && (a[1:0] == 2'b00);
  endfunction : slot_hit

  function automatic logic ctrl_hit(input logic [ADDR_W-1:0] a);
    return a == FIFO_TEST_CTRL;
  endfunction : ctrl_hit

  function automatic logic stat_hit(input logic [ADDR_W-1:0] a);
    return a == DATA_PATH_STATUS;
  endfunction : stat_hit

  assign setup   = psel && !penable;
  assign access  = psel && penable && pready_q;
  assign wr_slot = access && pwrite && slot_hit(paddr);
  assign rd_slot = access && !pwrite && slot_hit(paddr);
  assign wr_test = access && pwrite && ctrl_hit(paddr);
  assign rd_stat = access && !pwrite && stat_hit(paddr);

  // received byte from the framer of the active line mode
  assign line_v = ir_mode ? rx_ir_valid : rx_ser_valid;
  assign line_d = ir_mode ? rx_ir_data : rx_ser_data;

  // test mode feeds the receive FIFO from the bus and drains transmit to the bus
  assign rx_in_v    = fifo_en && (test_q ? wr_slot : line_v);
  assign rx_in_d    = test_q ? pwdata[CHAR_W-1:0] : line_d;
  assign rx_out_rdy = fifo_en && !test_q && rd_slot;
  assign tx_in_v    = fifo_en && !test_q && wr_slot;
  assign line_slot_free = !(txs_v_q || txi_v_q) || tx_char_ready;
  assign tx_out_rdy = fifo_en && (test_q ? rd_slot : line_slot_free);

  // any change of the test bit restarts both FIFOs empty
  assign clear_fifos = wr_test && FIFO_ACCESS && (pwdata[TEST_EN_BIT] != test_q);

  // overrun: a byte arrives with nowhere to go; with FIFOs off it still overwrites the receive buffer
  assign ovr_set = !test_q && line_v &&
                   (fifo_en ? !rx_in_rdy : (rx_full_q && !rd_slot));

  usdfta_fifo #(
    .WIDTH (CHAR_W),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clear     (clear_fifos),
    .in_valid  (rx_in_v),
    .in_ready  (rx_in_rdy),
    .in_data   (rx_in_d),
    .out_valid (rx_out_v),
    .out_ready (rx_out_rdy),
    .out_data  (rx_head)
  );

  usdfta_fifo #(
    .WIDTH (CHAR_W),
    .DEPTH (DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clear     (clear_fifos),
    .in_valid  (tx_in_v),
    .in_ready  (tx_in_rdy),
    .in_data   (pwdata[CHAR_W-1:0]),
    .out_valid (tx_out_v),
    .out_ready (tx_out_rdy),
    .out_data  (tx_head)
  );

  // apb: answer is prepared in the setup cycle, so access never waits
  always_comb begin
    prdata_d  = RD_ZERO;
    pslverr_d = 1'b0;
    pready_d  = setup;
    if (setup) begin
      if (slot_hit(paddr)) begin
        if (!pwrite) begin
          if (test_q) begin
            prdata_d[CHAR_W-1:0] = fifo_en ? tx_head : tx_hold_q;
          end else begin
            prdata_d[CHAR_W-1:0] = fifo_en ? rx_head : rx_buf_q;
          end
        end
      end else if (ctrl_hit(paddr)) begin
        prdata_d[TEST_EN_BIT] = test_q;
      end else if (stat_hit(paddr)) begin
        prdata_d[ST_RX_READY]      = rdy_q;
        prdata_d[ST_OVERRUN]       = ovr_q;
        prdata_d[ST_TX_EMPTY]      = tx_holding_empty_q;
        prdata_d[ST_RX_FULL]       = !rx_in_rdy;
        prdata_d[ST_RX_NOT_EMPTY]  = rx_out_v;
        prdata_d[ST_TX_FIFO_EMPTY] = !tx_out_v;
        prdata_d[ST_TX_FULL]       = !tx_in_rdy;
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  // data path next state
  always_comb begin
    test_d    = test_q;
    rx_buf_d  = rx_buf_q;
    rx_full_d = rx_full_q;
    tx_hold_d = tx_hold_q;
    tx_full_d = tx_full_q;
    ovr_d     = ovr_q;
    txs_v_d   = txs_v_q;
    txi_v_d   = txi_v_q;
    tx_out_d  = tx_out_q;

    if (wr_test && FIFO_ACCESS) begin
      test_d = pwdata[TEST_EN_BIT];
    end

    // line transmit stage: drop valid once the framer takes it
    if (tx_char_ready) begin
      txs_v_d = 1'b0;
      txi_v_d = 1'b0;
    end
    // a byte taken and a new one loaded in one cycle keeps valid high
    if (!test_q && line_slot_free) begin
      if (fifo_en && tx_out_v) begin
        tx_out_d = tx_head;
        txs_v_d  = !ir_mode;
        txi_v_d  = ir_mode;
      end else if (!fifo_en && tx_full_q) begin
        tx_out_d  = tx_hold_q;
        txs_v_d   = !ir_mode;
        txi_v_d   = ir_mode;
        tx_full_d = 1'b0;
      end
    end

    if (!fifo_en) begin
      if (!test_q && line_v) begin
        if (rx_full_q && !rd_slot) begin
          ovr_d = 1'b1;
        end
        rx_buf_d  = line_d;
        rx_full_d = 1'b1;
      end else if (!test_q && rd_slot) begin
        rx_full_d = 1'b0;
      end
      if (wr_slot) begin
        if (test_q) begin
          rx_buf_d  = pwdata[CHAR_W-1:0];
          rx_full_d = 1'b1;
        end else begin
          tx_hold_d = pwdata[CHAR_W-1:0];
          tx_full_d = 1'b1;
        end
      end
      if (test_q && rd_slot) begin
        tx_full_d = 1'b0;
      end
    end else if (line_v && !test_q && !rx_in_rdy) begin
      ovr_d = 1'b1;
    end

    // a read of status clears overrun, but an overrun in the same cycle wins,
    // even when the flag is already set, so no event is lost
    if (rd_stat && !ovr_set) begin
      ovr_d = 1'b0;
    end
    if (clear_fifos) begin
      rx_full_d = 1'b0;
      tx_full_d = 1'b0;
    end
  end

  // flags registered from the state they summarise; one cycle behind it
  always_comb begin
    rdy_d  = fifo_en ? rx_out_v : rx_full_q;
    tx_holding_empty_d = fifo_en ? !tx_out_v : !tx_full_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_q  <= RD_ZERO;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      test_q    <= TEST_EN_RESET;
      rx_buf_q  <= CHAR_RESET;
      rx_full_q <= 1'b0;
      tx_hold_q <= CHAR_RESET;
      tx_full_q <= 1'b0;
      ovr_q     <= 1'b0;
      txs_v_q   <= 1'b0;
      txi_v_q   <= 1'b0;
      tx_out_q  <= CHAR_RESET;
      rdy_q     <= 1'b0;
      tx_holding_empty_q    <= 1'b1;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      test_q    <= test_d;
      rx_buf_q  <= rx_buf_d;
      rx_full_q <= rx_full_d;
      tx_hold_q <= tx_hold_d;
      tx_full_q <= tx_full_d;
      ovr_q     <= ovr_d;
      txs_v_q   <= txs_v_d;
      txi_v_q   <= txi_v_d;
      tx_out_q  <= tx_out_d;
      rdy_q     <= rdy_d;
      tx_holding_empty_q    <= tx_holding_empty_d;
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign tx_ser_valid     = txs_v_q;
  assign tx_ir_valid      = txi_v_q;
  assign tx_char_data     = tx_out_q;
  assign rx_data_ready    = rdy_q;
  assign tx_holding_empty = tx_holding_empty_q;
  assign overrun_err      = ovr_q;

endmodule : usdfta_top

// >>> src/usdfta_pkg.sv
/*
  Constants for the shadow data window and FIFO test access block of a UART:
  register byte addresses, field positions, reset values and FIFO sizing.
  Assumes a 32-bit APB with full byte addresses and one aligned word per register.

*/
package usdfta_pkg;

  localparam int unsigned       ADDR_W           = 32;
  localparam int unsigned       DATA_W           = 32;
  localparam int unsigned       CHAR_W           = 8;
  localparam int unsigned       FIFO_DEPTH       = 16;

  // shadow slots: slot 15 sits at the top, slots are one word apart
  localparam logic [31:0]       SHADOW_SLOT15    = 32'h5000_116c;
  localparam logic [31:0]       SHADOW_SLOT0     = 32'h5000_1130;
  localparam logic [31:0]       FIFO_TEST_CTRL   = 32'h5000_1170;
  localparam logic [31:0]       DATA_PATH_STATUS = 32'h5000_1174;

  localparam int unsigned       TEST_EN_BIT      = 0;
  // status field positions
  localparam int unsigned       ST_RX_READY      = 0;
  localparam int unsigned       ST_OVERRUN       = 1;
  localparam int unsigned       ST_TX_EMPTY      = 5;
  localparam int unsigned       ST_RX_FULL       = 8;
  localparam int unsigned       ST_RX_NOT_EMPTY  = 9;
  localparam int unsigned       ST_TX_FIFO_EMPTY = 10;
  localparam int unsigned       ST_TX_FULL       = 11;

  localparam logic [31:0]       RD_ZERO          = 32'h0000_0000;
  localparam logic [7:0]        CHAR_RESET       = 8'h00;
  localparam logic              TEST_EN_RESET    = 1'b0;

endpackage : usdfta_pkg

// >>> tb/usdfta_top_assertions.sv
/*
  Port-level checker for usdfta_top: APB answer timing, decode errors,
  transmit handshake and receive flag timing.
  Assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/1ps

module usdfta_top_assertions (
  input wire logic                          clk,
  input wire logic                          sys_rst,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [usdfta_pkg::ADDR_W-1:0] paddr,
  input wire logic [usdfta_pkg::DATA_W-1:0] prdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  input wire logic                          ir_mode,
  input wire logic                          rx_ser_valid,
  input wire logic                          rx_ir_valid,
  input wire logic                          tx_ser_valid,
  input wire logic                          tx_ir_valid,
  input wire logic [usdfta_pkg::CHAR_W-1:0] tx_char_data,
  input wire logic                          tx_char_ready,
  input wire logic                          rx_data_ready
);
  import usdfta_pkg::*;

  logic mapped;

  assign mapped = paddr >= SHADOW_SLOT0 && paddr <= DATA_PATH_STATUS && paddr[1:0] == 2'h0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_setup;
    psel && !penable;
  endsequence
  // no bus access in the window, so no read can pop the byte first
  sequence s_rx_take;
    !psel && (ir_mode ? rx_ir_valid : rx_ser_valid) ##1 !psel;
  endsequence

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready high longer than one cycle");
  a_zero_wait: assert property (s_setup |=> pready)
    else $error("no answer in first access cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_unmapped_err: assert property (pready && !mapped |-> pslverr && prdata == RD_ZERO)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_byte_only: assert property (pready && !pwrite && paddr != DATA_PATH_STATUS
      |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_tx_hold: assert property ((tx_ser_valid || tx_ir_valid) && !tx_char_ready
      |=> $stable({tx_ser_valid, tx_ir_valid, tx_char_data}))
    else $error("transmit byte changed before taken");
  a_one_line: assert property (tx_ir_valid |-> ir_mode && !tx_ser_valid)
    else $error("transmit on the wrong line");
  a_rx_flag: assert property (s_rx_take |=> rx_data_ready)
    else $error("data ready not raised two edges after byte");

endmodule : usdfta_top_assertions

bind usdfta_top usdfta_top_assertions u_assert (.*);

// >>> tb/usdfta_line_model.sv
/*
  Line-side framer model: delivers received bytes on the line chosen by
  ir_mode and takes transmit bytes, withholding ready while stall is high.
  Assumes the bench's clock and reset; send is called from the bench.
*/
`timescale 1ns/1ps

module usdfta_line_model (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        ir_mode,
  input wire logic        stall,
  input wire logic        tx_ser_valid,
  input wire logic        tx_ir_valid,
  input wire logic [7:0]  tx_char_data,
  output logic            tx_char_ready,
  output logic            rx_ser_valid,
  output logic [7:0]      rx_ser_data,
  output logic            rx_ir_valid,
  output logic [7:0]      rx_ir_data,
  output logic [7:0]      last_q,
  output logic [15:0]     cnt_q
);
  // slow framer only withholds ready; it never takes a byte twice
  assign tx_char_ready = !stall;

  initial begin
    rx_ser_valid = 1'b0;
    rx_ir_valid  = 1'b0;
    rx_ser_data  = 8'h00;
    rx_ir_data   = 8'hFF;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q  <= 16'h0000;
      last_q <= 8'h00;
    end else if ((tx_ser_valid || tx_ir_valid) && tx_char_ready) begin
      cnt_q  <= cnt_q + 16'h0001;
      last_q <= tx_char_data;
    end
  end

  task automatic send(input logic [7:0] b);
    @(posedge clk);
    rx_ser_valid <= !ir_mode;
    rx_ir_valid  <= ir_mode;
    rx_ser_data  <= b;
    rx_ir_data   <= b;
    @(posedge clk);
    rx_ser_valid <= 1'b0;
    rx_ir_valid  <= 1'b0;
    // a released line must not keep showing the byte
    rx_ser_data  <= ~b;
    rx_ir_data   <= ~b;
  endtask : send

endmodule : usdfta_line_model

// >>> tb/uart_shadow_data_fifo_test_access_test.sv
/*
  Bench for usdfta_top: APB tasks, a line-side framer model and data checks.
  Assumes usdfta_pkg, the line model and the bound checker are compiled first.
*/
`timescale 1ns/1ps

module uart_shadow_data_fifo_test_access_test;
  import usdfta_pkg::*;

  localparam int unsigned DEPTH_T = 8;
  localparam logic [31:0] ALL     = 32'hFFFF_FFFF;
  localparam logic [31:0] ONE     = 32'h0000_0001;

  logic        clk, sys_rst, psel, penable, pwrite, fifo_en, ir_mode, stall, err_seen;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic        pready, pslverr, tx_ser_valid, tx_ir_valid, tx_char_ready;
  logic        rx_ser_valid, rx_ir_valid, rx_data_ready, tx_holding_empty, overrun_err;
  logic [7:0]  rx_ser_data, rx_ir_data, tx_char_data, last_q;
  logic [15:0] cnt_q;
  int          num_errors, cmp_count;

  usdfta_top #(.DEPTH(DEPTH_T)) u_dut (.*);
  usdfta_line_model u_line (.*);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic complete_run;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd       = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("access cycles", ONE, 32'(n));
  endtask : apb

  task automatic rdchk(input string what, input logic [31:0] a, m, e);
    apb(1'b0, a, RD_ZERO);
    chk(what, e, rd & m);
  endtask : rdchk

  function automatic logic [31:0] slot(input int i);
    return SHADOW_SLOT0 + 32'(4 * i);
  endfunction : slot

  function automatic logic [31:0] b32(input logic b);
    return {31'h0000_0000, b};
  endfunction : b32

  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, ir_mode, stall} = 5'h00;
    {paddr, pwdata} = 64'h0000_0000_0000_0000;
    fifo_en = 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk("test bit", FIFO_TEST_CTRL, ALL, RD_ZERO);
    rdchk("status", DATA_PATH_STATUS, 32'h0000_0F23, 32'h0000_0420);
    rdchk("unmapped", 32'h5000_1200, ALL, RD_ZERO);
    chk("slverr", ONE, b32(err_seen));
    for (int i = 0; i <= DEPTH_T; i++) u_line.send(8'hA0 + 8'(i));
    repeat (3) @(posedge clk);
    chk("overrun", ONE, b32(overrun_err));
    rdchk("rx full", DATA_PATH_STATUS, 32'h0000_0102, 32'h0000_0102);
    for (int i = 0; i < DEPTH_T; i++) rdchk("rx head", slot(8 + i), ALL, 32'h0000_00A0 + i);
    repeat (2) @(posedge clk);
    chk("rx empty", RD_ZERO, b32(rx_data_ready));
    ir_mode <= 1'b1;
    u_line.send(8'h5C);
    repeat (3) @(posedge clk);
    rdchk("ir rx", slot(3), ALL, 32'h0000_005C);
    stall <= 1'b1;
    // one byte waits in the line stage, DEPTH_T in the FIFO, the last write is dropped
    for (int i = 0; i <= DEPTH_T + 1; i++) apb(1'b1, slot(i), 32'h0000_00C0 + i);
    rdchk("tx full", DATA_PATH_STATUS, 32'h0000_0800, 32'h0000_0800);
    stall <= 1'b0;
    repeat (30) @(posedge clk);
    chk("tx count", 32'(DEPTH_T + 1), 32'(cnt_q));
    chk("tx last", 32'h0000_00C8, 32'(last_q));
    ir_mode <= 1'b0;
    fifo_en <= 1'b0;
    u_line.send(8'h11);
    u_line.send(8'h22);
    repeat (3) @(posedge clk);
    rdchk("rx overwrite", slot(5), ALL, 32'h0000_0022);
    rdchk("overrun bit", DATA_PATH_STATUS, 32'h0000_0002, 32'h0000_0002);
    stall <= 1'b1;
    apb(1'b1, slot(0), 32'h0000_0031);
    repeat (3) @(posedge clk);
    apb(1'b1, slot(1), 32'h0000_0032);
    repeat (2) @(posedge clk);
    chk("holding empty", RD_ZERO, b32(tx_holding_empty));
    apb(1'b1, slot(2), 32'h0000_0033);
    stall <= 1'b0;
    repeat (20) @(posedge clk);
    chk("tx sent", 32'(DEPTH_T + 3), 32'(cnt_q));
    chk("tx replaced", 32'h0000_0033, 32'(last_q));
    fifo_en <= 1'b1;
    u_line.send(8'h44);
    repeat (3) @(posedge clk);
    apb(1'b1, FIFO_TEST_CTRL, ONE);
    repeat (2) @(posedge clk);
    chk("flush on", RD_ZERO, b32(rx_data_ready));
    rdchk("test on", FIFO_TEST_CTRL, ALL, ONE);
    apb(1'b1, slot(9), 32'h0000_0066);
    repeat (2) @(posedge clk);
    chk("test push", ONE, b32(rx_data_ready));
    apb(1'b1, FIFO_TEST_CTRL, RD_ZERO);
    repeat (2) @(posedge clk);
    chk("flush off", RD_ZERO, b32(rx_data_ready));
    fifo_en <= 1'b0;
    apb(1'b1, FIFO_TEST_CTRL, ONE);
    apb(1'b1, slot(4), 32'h0000_0077);
    repeat (2) @(posedge clk);
    chk("rx write", ONE, b32(rx_data_ready));
    rdchk("holding read", slot(7), ALL, 32'h0000_0033);
    complete_run();
  end

  // the sequence needs well under 2000 cycles
  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    complete_run();
  end

endmodule : uart_shadow_data_fifo_test_access_test
